// file: hw/soft_reset_controller.v
/*
  Soft reset controller: gathers firmware, watchdog, lockup and system
  request reset sources, times one soft reset pulse, keeps sticky cause
  flags and gates pad output enables while any reset is in effect.
  Assumes source inputs and the ring oscillator are asynchronous to clk,
  pad enable requests come from clk-domain logic, and srst is the hard
  reset (power-on or external pin) already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "soft_reset_defines.vh"

module soft_reset_controller #(
  parameter ADDR_W   = 16,
  parameter NUM_PADS = 32
) (
  // Clock and hard reset
  input  wire                clk,
  input  wire                srst,
  // Register port
  input  wire [ADDR_W-1:0]   reg_addr,
  input  wire [31:0]         reg_wdata,
  input  wire                reg_wr,
  input  wire                reg_rd,
  output reg  [31:0]         reg_rdata,
  // Reset sources, asynchronous to clk
  input  wire                watchdog_enable,
  input  wire                watchdog_expire,
  input  wire                cpu_lockup,
  input  wire                cpu_system_request,
  input  wire                ring_osc_clk,
  // Pad output enable requests from functional logic
  input  wire [NUM_PADS-1:0] pad_oe_req,
  // Reset and pad outputs
  output reg                 soft_reset,
  output reg                 device_reset,
  output reg  [NUM_PADS-1:0] pad_oe,
  // Interrupt
  output reg                 irq
);

  // Synchroniser stages and edge history
  reg  [`SYN_N-1:0]  syn1_r;
  reg  [`SYN_N-1:0]  syn2_r;
  reg  [`SYN_N-1:0]  syn3_r;
  wire [`SYN_N-1:0]  src_in;
  wire [`SYN_N-1:0]  src_rise;

  // Registers
  reg                watchdog_expiry_flag_r;
  reg                firmware_reset_request_r;
  reg                lockup_flag_r;
  reg                cpu_system_request_flag_r;
  reg  [`CNT_W-1:0]  soft_reset_pulse_count_r;
  reg  [`IRQ_W-1:0]  irq_status_r;
  reg  [`IRQ_W-1:0]  irq_mask_r;
  reg  [`IRQ_W-1:0]  irq_status_nxt;
  reg  [`IRQ_W-1:0]  irq_mask_nxt;
  reg  [31:0]        rdata_nxt;

  // Decode and events
  wire               sel_ctl;
  wire               sel_stat;
  wire               sel_mask;
  wire               sel_cnt;
  wire               wr_ok;
  wire               fw_ev;
  wire               wd_ev;
  wire               lock_ev;
  wire               sys_ev;
  wire               start;
  wire               tick;
  wire               busy;
  wire               done;
  wire               reset_active;
  wire [`CTL_W-1:0]  ctl_view;

  assign src_in = {cpu_system_request, cpu_lockup, watchdog_expire,
                   watchdog_enable, ring_osc_clk};

  // Two-flop synchroniser plus one history flop per source
  genvar gi;
  generate
    for (gi = 0; gi < `SYN_N; gi = gi + 1) begin : g_sync
      always @(posedge clk) begin
        if (srst) begin
          syn1_r[gi] <= 1'b0;
          syn2_r[gi] <= 1'b0;
          syn3_r[gi] <= 1'b0;
        end else begin
          syn1_r[gi] <= src_in[gi];
          syn2_r[gi] <= syn1_r[gi];
          syn3_r[gi] <= syn2_r[gi];
        end
      end
      assign src_rise[gi] = syn2_r[gi] & ~syn3_r[gi];
    end
  endgenerate

  // Address decode
  assign sel_ctl  = (reg_addr == `SRC_CTL_OFF);
  assign sel_stat = (reg_addr == `SRC_IRQ_STAT_OFF);
  assign sel_mask = (reg_addr == `SRC_IRQ_MASK_OFF);
  assign sel_cnt  = (reg_addr == `SRC_PULSE_CNT_OFF);

  // Writes are dropped while the soft reset is running
  assign wr_ok = reg_wr & ~busy;

  // Reset source events
  assign fw_ev   = wr_ok & sel_ctl & reg_wdata[`CTL_FW_BIT];
  assign wd_ev   = src_rise[`SYN_WD_EXP] & syn2_r[`SYN_WD_EN];
  assign lock_ev = src_rise[`SYN_LOCK];
  assign sys_ev  = src_rise[`SYN_SYS];
  assign tick    = src_rise[`SYN_RING];

  // Requests that coincide, or arrive mid-pulse, give one pulse
  assign start = (fw_ev | wd_ev | lock_ev | sys_ev) & ~busy;

  assign reset_active = busy | start;

  // Pulse length timer in ring oscillator ticks
  reset_pulse_timer #(
    .CNT_W (`CNT_W)
  ) u_timer (
    .clk        (clk),
    .srst       (srst),
    .start      (start),
    .load_count (soft_reset_pulse_count_r),
    .tick       (tick),
    .busy       (busy),
    .done       (done)
  );

  // Firmware request bit: set by write, self-clears at pulse end
  always @(posedge clk) begin
    if (srst) begin
      firmware_reset_request_r <= 1'b0;
    end else if (fw_ev && !busy) begin
      firmware_reset_request_r <= 1'b1;
    end else if (done) begin
      firmware_reset_request_r <= 1'b0;
    end
  end

  // Watchdog cause flag, sticky across soft reset
  always @(posedge clk) begin
    if (srst) begin
      watchdog_expiry_flag_r <= 1'b0;
    end else if (wd_ev) begin
      watchdog_expiry_flag_r <= 1'b1;
    end else if (wr_ok && sel_ctl && reg_wdata[`CTL_WD_BIT]) begin
      watchdog_expiry_flag_r <= 1'b0;
    end
  end

  // Lockup cause flag, sticky across soft reset
  always @(posedge clk) begin
    if (srst) begin
      lockup_flag_r <= 1'b0;
    end else if (lock_ev) begin
      lockup_flag_r <= 1'b1;
    end else if (wr_ok && sel_ctl && reg_wdata[`CTL_LOCK_BIT]) begin
      lockup_flag_r <= 1'b0;
    end
  end

  // System request cause flag, sticky across soft reset
  always @(posedge clk) begin
    if (srst) begin
      cpu_system_request_flag_r <= 1'b0;
    end else if (sys_ev) begin
      cpu_system_request_flag_r <= 1'b1;
    end else if (wr_ok && sel_ctl && reg_wdata[`CTL_SYS_BIT]) begin
      cpu_system_request_flag_r <= 1'b0;
    end
  end

  // Pulse count: returns to its default under any reset
  always @(posedge clk) begin
    if (srst || reset_active) begin
      soft_reset_pulse_count_r <= `CNT_RESET;
    end else if (wr_ok && sel_cnt) begin
      soft_reset_pulse_count_r <= reg_wdata[`CNT_W-1:0];
    end
  end

  // Interrupt status: events set, write one clears, set wins
  always @* begin
    irq_status_nxt = irq_status_r;
    if (wr_ok && sel_stat) begin
      irq_status_nxt = irq_status_r & ~reg_wdata[`IRQ_W-1:0];
    end
    irq_status_nxt[`IRQ_WD_BIT]   = irq_status_nxt[`IRQ_WD_BIT] | wd_ev;
    irq_status_nxt[`IRQ_FW_BIT]   = irq_status_nxt[`IRQ_FW_BIT] | (fw_ev & ~busy);
    irq_status_nxt[`IRQ_LOCK_BIT] = irq_status_nxt[`IRQ_LOCK_BIT] | lock_ev;
    irq_status_nxt[`IRQ_SYS_BIT]  = irq_status_nxt[`IRQ_SYS_BIT] | sys_ev;
    irq_status_nxt[`IRQ_DONE_BIT] = irq_status_nxt[`IRQ_DONE_BIT] | done;
  end

  // Mask next value, so irq follows a mask write in the same cycle
  always @* begin
    irq_mask_nxt = irq_mask_r;
    if (wr_ok && sel_mask) begin
      irq_mask_nxt = reg_wdata[`IRQ_W-1:0];
    end
  end

  // Interrupt status and mask survive soft reset
  always @(posedge clk) begin
    if (srst) begin
      irq_status_r <= `IRQ_RESET;
      irq_mask_r   <= `IRQ_RESET;
    end else begin
      irq_status_r <= irq_status_nxt;
      irq_mask_r   <= irq_mask_nxt;
    end
  end

  // Control register view, upper bits fixed at zero
  assign ctl_view = {4'h0,
                     cpu_system_request_flag_r,
                     lockup_flag_r,
                     firmware_reset_request_r,
                     watchdog_expiry_flag_r};

  // Read mux, unmapped addresses read zero
  always @* begin
    rdata_nxt = 32'h00000000;
    if (reg_rd) begin
      if (sel_ctl) begin
        rdata_nxt = {24'h000000, ctl_view};
      end else if (sel_stat) begin
        rdata_nxt = {27'h0000000, irq_status_r};
      end else if (sel_mask) begin
        rdata_nxt = {27'h0000000, irq_mask_r};
      end else if (sel_cnt) begin
        rdata_nxt = {16'h0000, soft_reset_pulse_count_r};
      end
    end
  end

  // Read data stands for the one cycle after the strobe
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Reset outputs: device_reset under hard reset or soft pulse, soft_reset only under the soft pulse
  always @(posedge clk) begin
    if (srst) begin
      soft_reset   <= 1'b0;
      device_reset <= 1'b1;
    end else begin
      soft_reset   <= reset_active;
      device_reset <= reset_active;
    end
  end

  // Pad drivers released only when no reset is in effect
  generate
    for (gi = 0; gi < NUM_PADS; gi = gi + 1) begin : g_pad
      always @(posedge clk) begin
        if (srst) begin
          pad_oe[gi] <= 1'b0;
        end else begin
          pad_oe[gi] <= pad_oe_req[gi] & ~reset_active;
        end
      end
    end
  endgenerate

  // Level interrupt from unmasked status bits
  always @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_nxt & irq_mask_nxt);
    end
  end

endmodule // soft_reset_controller

`default_nettype wire

// file: shared/soft_reset_defines.vh
/*
  Constants of the soft reset controller: register byte offsets, field
  positions, reset values and interrupt bit layout.
  Assumes a byte-addressed register port with 32-bit data.
*/
`ifndef SOFT_RESET_DEFINES_VH
`define SOFT_RESET_DEFINES_VH

// Register byte offsets
`define SRC_CTL_OFF        16'h0420
`define SRC_IRQ_STAT_OFF   16'h0424
`define SRC_IRQ_MASK_OFF   16'h0428
`define SRC_PULSE_CNT_OFF  16'h0704

// Control register fields
`define CTL_WD_BIT         0
`define CTL_FW_BIT         1
`define CTL_LOCK_BIT       2
`define CTL_SYS_BIT        3
`define CTL_W              8
`define CTL_RESET          8'h00

// Pulse count register
`define CNT_W              16
`define CNT_RESET          16'h0097

// Interrupt status and mask fields
`define IRQ_WD_BIT         0
`define IRQ_FW_BIT         1
`define IRQ_LOCK_BIT       2
`define IRQ_SYS_BIT        3
`define IRQ_DONE_BIT       4
`define IRQ_W              5
`define IRQ_RESET          5'h00

// Synchroniser slots
`define SYN_RING           0
`define SYN_WD_EN          1
`define SYN_WD_EXP         2
`define SYN_LOCK           3
`define SYN_SYS            4
`define SYN_N              5

`endif

// file: hw/reset_pulse_timer.v
/*
  Soft reset pulse timer: counts ring oscillator ticks for the length
  of one soft reset pulse.
  Assumes tick is a one-cycle pulse already in the clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "soft_reset_defines.vh"

module reset_pulse_timer #(
  parameter CNT_W = `CNT_W
) (
  // Clock and hard reset
  input  wire             clk,
  input  wire             srst,
  // Control
  input  wire             start,
  input  wire [CNT_W-1:0] load_count,
  input  wire             tick,
  // Status
  output reg              busy,
  output reg              done
);

  reg  [CNT_W-1:0] remain_r;
  wire [CNT_W-1:0] load_m1;

  // Pulse spans count minus one ticks, never less than one
  assign load_m1 = (load_count < {{(CNT_W-1){1'b0}}, 1'b1} + {{(CNT_W-1){1'b0}}, 1'b1}) ?
                   {{(CNT_W-1){1'b0}}, 1'b1} :
                   load_count - {{(CNT_W-1){1'b0}}, 1'b1};

  // Load on start, count down on each tick, flag the last tick
  always @(posedge clk) begin
    if (srst) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      remain_r <= {CNT_W{1'b0}};
    end else begin
      done <= 1'b0;
      if (!busy && start) begin
        busy     <= 1'b1;
        remain_r <= load_m1;
      end else if (busy && tick) begin
        if (remain_r == {{(CNT_W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        remain_r <= remain_r - {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // reset_pulse_timer

`default_nettype wire

// file: test/soft_reset_controller_asserts.sv
/* Port checker of the soft reset controller.
   Assumes one clock domain and binding to the top module. */
`timescale 1ns/1ps
`default_nettype none
module soft_reset_controller_asserts #(
  parameter ADDR_W   = 16,
  parameter NUM_PADS = 32
) (
  // Clock, reset, register port
  input wire logic                clk,
  input wire logic                srst,
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [31:0]         reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [31:0]         reg_rdata,
  // Sources
  input wire logic                watchdog_enable,
  input wire logic                watchdog_expire,
  input wire logic                cpu_lockup,
  input wire logic                cpu_system_request,
  input wire logic                ring_osc_clk,
  // Pads and outputs
  input wire logic [NUM_PADS-1:0] pad_oe_req,
  input wire logic                soft_reset,
  input wire logic                device_reset,
  input wire logic [NUM_PADS-1:0] pad_oe,
  input wire logic                irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Reset effects on outputs
  a_hard_reset_out: assert property (disable iff (1'b0) srst |=>
    device_reset && !soft_reset && !irq && pad_oe == '0) else $error("hard reset outputs");
  a_soft_in_dev: assert property (soft_reset |-> device_reset && pad_oe == '0)
    else $error("soft pulse outputs");
  a_pad_follow: assert property (!device_reset && !$past(device_reset)
    |-> pad_oe == $past(pad_oe_req)) else $error("pad enable not passed");
  // Pulse starts and length
  a_fw_start: assert property (reg_wr && reg_addr == 16'h0420 && reg_wdata[1]
    && !soft_reset |=> soft_reset) else $error("fw request no pulse");
  a_pulse_bound: assert property ($rose(soft_reset) |-> ##[1:1000] !soft_reset)
    else $error("pulse too long");
  a_lock_start: assert property ($rose(cpu_lockup) && !soft_reset |-> ##[1:6] soft_reset)
    else $error("lockup no pulse");
  a_sys_start: assert property ($rose(cpu_system_request) && !soft_reset
    |-> ##[1:6] soft_reset) else $error("system request no pulse");
  a_wd_start: assert property ($rose(watchdog_expire) && watchdog_enable
    && $past(watchdog_enable, 4) && !soft_reset |-> ##[1:6] soft_reset) else $error("wd no pulse");
  // Main scenarios
  c_pulse: cover property ($rose(soft_reset));
  c_irq: cover property ($rose(irq));
  c_both: cover property ($rose(cpu_lockup) && $rose(cpu_system_request));
endmodule // soft_reset_controller_asserts
bind soft_reset_controller soft_reset_controller_asserts #(
  .ADDR_W(ADDR_W), .NUM_PADS(NUM_PADS)) chk (.*);
`default_nettype wire

// file: test/reset_source_model.sv
/* Far side model: watchdog, core lockup and system request, ring
   oscillator. Assumes the bench calls fire. */
`timescale 1ns/1ps
`default_nettype none
module reset_source_model (
  // Source lines, asynchronous to clk
  output var logic watchdog_enable,
  output var logic watchdog_expire,
  output var logic cpu_lockup,
  output var logic cpu_system_request,
  output var logic ring_osc_clk
);
  // Free ring oscillator, 13 ns, unrelated to clk; the quarter
  // nanosecond offset keeps its edges off the clk edges
  initial begin
    ring_osc_clk = 1'b0;
    #0.25;
    forever #6.5 ring_osc_clk = ~ring_osc_clk;
  end
  // Idle levels
  initial begin
    watchdog_enable = 1'b0;
    {watchdog_expire, cpu_lockup, cpu_system_request} = 3'b000;
  end
  // Bit 3 enable, then bits 2:0 pulse system, lockup, watchdog
  task fire(input logic [3:0] w);
    begin
      watchdog_enable = w[3];
      #21.3;
      {cpu_system_request, cpu_lockup, watchdog_expire} = w[2:0];
      #40;
      {cpu_system_request, cpu_lockup, watchdog_expire} = 3'b000;
    end
  endtask
endmodule // reset_source_model
`default_nettype wire

// file: test/soft_reset_controller_bench.sv
/* Bench of the soft reset controller: register tasks, source model,
   cause flags, pulse length, pads and interrupt. Assumes 250 MHz. */
`timescale 1ns/1ps
`default_nettype none
module soft_reset_controller_bench;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, pad_oe;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, we, wx, lk, sq, ro;
  logic        soft_reset, device_reset, irq;
  int          n_mismatch = 0, checked = 0, len, i, run_len = 0, last_len = 0;
  logic [31:0] pad_req = 32'hFFFFFFFF;
  logic        len_ok;
  // Clock
  always #2 clk = ~clk;
  reset_source_model src (.watchdog_enable(we), .watchdog_expire(wx), .cpu_lockup(lk),
    .cpu_system_request(sq), .ring_osc_clk(ro));
  soft_reset_controller dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .watchdog_enable(we), .watchdog_expire(wx), .cpu_lockup(lk),
    .cpu_system_request(sq), .ring_osc_clk(ro), .pad_oe_req(pad_req),
    .soft_reset(soft_reset), .device_reset(device_reset), .pad_oe(pad_oe), .irq(irq));
  // Verdict
  task wrap_up;
    begin
      $display("mismatches %0d comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // Compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked++;
      if (got !== exp) begin
        n_mismatch++;
        $display("Error at %0t got %0h expected %0h", $time, got, exp);
      end
    end
  endtask
  // Register write and read
  task wr(input logic [15:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1;
    end
  endtask
  task rd(input logic [15:0] a, input logic [31:0] e);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, e);
    end
  endtask
  // Whole pulse length in clk cycles, latched when the pulse ends
  always @(posedge clk) begin
    if (soft_reset === 1'b1) begin
      run_len <= run_len + 1;
    end else if (run_len != 0) begin
      last_len <= run_len;
      run_len <= 0;
    end
  end
  // Wait out one pulse and check its whole length in cycles
  task pulse(input int n);
    begin
      for (i = 0; i < 20 && soft_reset !== 1'b1; i++) @(negedge clk);
      for (len = 0; len < 1000 && soft_reset !== 1'b0; len++) @(negedge clk);
      if (i == 20 || len == 1000) begin
        n_mismatch++;
        wrap_up;
      end
      @(negedge clk);
      len_ok = last_len >= ((n - 2) * 13) / 4 && last_len <= ((n - 1) * 13) / 4 + 6;
      chk({31'h0, len_ok}, 32'h1);
    end
  endtask
  // Main sequence
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    rd(16'h0420, 32'h00);
    rd(16'h0704, 32'h0097);
    rd(16'h0500, 32'h00);
    wr(16'h0420, 32'hF0);
    rd(16'h0420, 32'h00);
    // Firmware pulse, short count
    wr(16'h0428, 32'h1F);
    wr(16'h0704, 32'h0004);
    wr(16'h0420, 32'h02);
    @(negedge clk);
    chk(pad_oe, 32'h0);
    chk({30'h0, soft_reset, device_reset}, 32'h3);
    rd(16'h0420, 32'h02);
    wr(16'h0428, 32'h00);
    pulse(4);
    rd(16'h0420, 32'h00);
    rd(16'h0704, 32'h0097);
    rd(16'h0428, 32'h1F);
    rd(16'h0424, 32'h12);
    // Pad enables follow the request pattern once reset is over
    @(posedge clk);
    pad_req <= 32'hC3A5F00F;
    repeat (2) @(negedge clk);
    chk(pad_oe, 32'hC3A5F00F);
    chk({30'h0, pad_oe[0], irq}, 32'h3);
    wr(16'h0424, 32'h1F);
    chk({31'h0, irq}, 32'h0);
    // Lockup, then system request
    src.fire(4'b0010);
    pulse(151);
    rd(16'h0420, 32'h04);
    src.fire(4'b0100);
    pulse(151);
    rd(16'h0420, 32'h0C);
    wr(16'h0420, 32'h04);
    rd(16'h0420, 32'h08);
    wr(16'h0420, 32'h00);
    rd(16'h0420, 32'h08);
    // Watchdog off, then on
    src.fire(4'b0001);
    chk({31'h0, soft_reset}, 32'h0);
    rd(16'h0420, 32'h08);
    src.fire(4'b1001);
    pulse(151);
    rd(16'h0420, 32'h09);
    // Coincident sources make one pulse
    wr(16'h0420, 32'h0D);
    wr(16'h0424, 32'h1F);
    src.fire(4'b0110);
    pulse(151);
    repeat (20) @(negedge clk);
    chk({31'h0, soft_reset}, 32'h0);
    rd(16'h0420, 32'h0C);
    rd(16'h0424, 32'h1C);
    // Interrupt masking
    wr(16'h0428, 32'h00);
    chk({31'h0, irq}, 32'h0);
    wr(16'h0428, 32'h04);
    chk({31'h0, irq}, 32'h1);
    // Hard reset clears causes
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    rd(16'h0420, 32'h00);
    rd(16'h0424, 32'h00);
    wrap_up;
  end
endmodule // soft_reset_controller_bench
`default_nettype wire
